// >>> rtl/ssc_pkg.sv
// Purpose: Shared constants for the servo serial command handler ends.
// Assumes: Frames are already parsed into command, data number, length and data.
// Notes: Data lengths count characters; one character is one hex nibble.
package ssc_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CMD_W = 8;
  localparam int DATA_W = 32;
  localparam int LEN_W = 4;
  localparam int DP_W = 8;
  localparam int VAL_W = 24;
  localparam int BCD_W = 40;
  localparam int PAR_NUM = 91;
  localparam int PIDX_W = 7;
  localparam int CONV_STEPS = 32;

  // ----------------------------------------------------------------
  // Commands and data numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STAT_RD = 8'h01;
  localparam logic [7:0] CMD_PAR_RD = 8'h05;
  localparam logic [7:0] CMD_STAT_CLR = 8'h81;
  localparam logic [7:0] CMD_PAR_WR = 8'h84;
  localparam logic [7:0] CMD_MODE = 8'h8B;
  localparam logic [7:0] CMD_IN_DIS = 8'h90;
  localparam logic [7:0] CMD_TEST_IO = 8'h92;
  localparam logic [7:0] CMD_GROUP = 8'h9F;
  localparam logic [7:0] CMD_TEST = 8'hA0;
  localparam logic [7:0] DNO_00 = 8'h00;
  localparam logic [7:0] DNO_IN_EN = 8'h10;
  localparam logic [7:0] DNO_FORCE_OUT = 8'hA0;
  localparam logic [7:0] DNO_SPEED = 8'h10;
  localparam logic [7:0] DNO_ACC = 8'h11;
  localparam logic [7:0] DNO_ACC_CLR = 8'h12;
  localparam logic [7:0] DNO_DIST = 8'h13;
  localparam logic [7:0] DNO_PAUSE = 8'h15;
  localparam logic [7:0] DNO_PAR_MAX = 8'h5A;
  localparam logic [7:0] DNO_STAT_FB = 8'h80;

  // ----------------------------------------------------------------
  // Values, limits and layouts
  // ----------------------------------------------------------------
  localparam logic [3:0] LEN4 = 4'h4;
  localparam logic [3:0] LEN8 = 4'h8;
  localparam logic [15:0] KEY = 16'h1EA5;
  localparam logic [15:0] MODE_MAX = 16'h0004;
  localparam logic [2:0] MODE_EXIT = 3'h0;
  localparam logic [15:0] SPEED_MAX = 16'h7FFF;
  localparam logic [7:0] GRP_LO = 8'h61;
  localparam logic [7:0] GRP_HI = 8'h66;
  localparam logic [7:0] GRP_NONE = 8'h00;
  localparam logic [PIDX_W-1:0] PAR_INH_IDX = 7'h13;
  localparam logic [VAL_W-1:0] PAR_INH_RD_OFF = 24'h00000E;
  localparam logic [DP_W-1:0] DP_NONE = 8'h00;
  localparam logic DISP_CONV = 1'b0;
  localparam logic DISP_RAW = 1'b1;
  localparam int EMG_BIT = 16;
  localparam int LSP_BIT = 1;
  localparam int LSN_BIT = 2;
  localparam logic [DATA_W-1:0] KEEP_MASK = 32'h00010006;
  localparam logic [3:0] BCD_ADJ_MIN = 4'h5;
  localparam logic [3:0] BCD_ADJ = 4'h3;
endpackage

// >>> rtl/ssc_link_if.sv
// Purpose: Word-level link between master station and servo slave.
// Assumes: One request outstanding at a time; both ends on sys_clk_i.
// Notes: Request and reply valid are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface ssc_link_if;
  import ssc_pkg::*;
  logic req_valid;
  logic [CMD_W-1:0] req_cmd;
  logic [CMD_W-1:0] req_dno;
  logic [LEN_W-1:0] req_len;
  logic [DATA_W-1:0] req_data;
  logic resp_valid;
  logic resp_ok;
  logic resp_disp;
  logic [DP_W-1:0] resp_dp;
  logic resp_rden;
  logic [DATA_W-1:0] resp_data;
  modport dev (
    input req_valid, req_cmd, req_dno, req_len, req_data,
    output resp_valid, resp_ok, resp_disp, resp_dp, resp_rden, resp_data
  );
  modport host (
    output req_valid, req_cmd, req_dno, req_len, req_data,
    input resp_valid, resp_ok, resp_disp, resp_dp, resp_rden, resp_data
  );
endinterface
`default_nettype wire

// >>> rtl/ssc_slave.sv
// Purpose: Servo slave command interpreter for the master/slave link.
// Assumes: Requests arrive already parsed; one reply per request.
// Notes: Refused requests still get a reply, with the ok flag low.
`timescale 1ns/1ps
`default_nettype none
module ssc_slave #(
  parameter int PAR_N = ssc_pkg::PAR_NUM,
  parameter logic [ssc_pkg::PAR_NUM-1:0] DEC_MASK = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Link to master
  ssc_link_if.dev link,
  // Drive feedback
  input wire logic fb_pulse_i,
  input wire logic fb_dir_i,
  // Raw inputs
  input wire logic forced_stop_input_i,
  input wire logic forward_stroke_limit_i,
  input wire logic reverse_stroke_limit_i,
  input wire logic [ssc_pkg::DATA_W-1:0] other_inputs_i,
  // Test operation settings
  output logic [2:0] mode_o,
  output logic [ssc_pkg::DATA_W-1:0] test_inputs_o,
  output logic [ssc_pkg::DATA_W-1:0] forced_outputs_o,
  output logic [15:0] test_speed_o,
  output logic [ssc_pkg::DATA_W-1:0] test_accel_o,
  output logic [ssc_pkg::DATA_W-1:0] test_dist_o,
  output logic test_pause_o,
  output logic [7:0] group_o,
  // Gated inputs
  output logic inputs_disabled_o,
  output logic [ssc_pkg::DATA_W-1:0] dev_inputs_o
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire logic req = link.req_valid;
  wire logic [7:0] cmd = link.req_cmd;
  wire logic [7:0] dno = link.req_dno;
  wire logic [DATA_W-1:0] dat = link.req_data;
  wire logic len4 = (link.req_len == LEN4);
  wire logic len8 = (link.req_len == LEN8);
  wire logic key_ok = len4 && (dat[15:0] == KEY);
  wire logic test_cmd = (cmd == CMD_TEST);
  wire logic [PIDX_W-1:0] pidx = dno[PIDX_W-1:0];
  wire logic pidx_ok = (dno <= DNO_PAR_MAX);

  wire logic mode_ok = (cmd == CMD_MODE) && (dno == DNO_00) && len4
    && (dat[15:0] <= MODE_MAX);
  wire logic tin_ok = (cmd == CMD_TEST_IO) && (dno == DNO_00) && len8;
  wire logic fout_ok = (cmd == CMD_TEST_IO) && (dno == DNO_FORCE_OUT) && len8;
  wire logic spd_ok = test_cmd && (dno == DNO_SPEED) && len4
    && (dat[15:0] <= SPEED_MAX);
  wire logic acc_ok = test_cmd && (dno == DNO_ACC) && len8 && !dat[DATA_W-1];
  wire logic accclr_ok = test_cmd && (dno == DNO_ACC_CLR) && key_ok;
  wire logic dist_ok = test_cmd && (dno == DNO_DIST) && len8;
  wire logic pause_ok = test_cmd && (dno == DNO_PAUSE) && key_ok;
  wire logic grp_ok = (cmd == CMD_GROUP) && (dno == DNO_00) && len4
    && (dat[7:0] >= GRP_LO) && (dat[7:0] <= GRP_HI);
  wire logic srd_ok = (cmd == CMD_STAT_RD) && (dno == DNO_STAT_FB);
  wire logic sclr_ok = (cmd == CMD_STAT_CLR) && (dno == DNO_00) && key_ok;
  wire logic prd_ok = (cmd == CMD_PAR_RD) && pidx_ok;
  wire logic idis_ok = (cmd == CMD_IN_DIS) && (dno == DNO_00) && key_ok;
  wire logic ien_ok = (cmd == CMD_IN_DIS) && (dno == DNO_IN_EN) && key_ok;

  // Leading characters hold the point position, trailing ones the value.
  wire logic [DP_W-1:0] wr_dp = dat[DATA_W-1 -: DP_W];
  wire logic [VAL_W-1:0] wr_val = dat[VAL_W-1:0];
  wire logic par_dec = DEC_MASK[pidx];
  wire logic pwr_ok = (cmd == CMD_PAR_WR) && pidx_ok && len8
    && !(par_dec && (wr_dp == DP_NONE));

  wire logic any_ok = mode_ok || tin_ok || fout_ok || spd_ok || acc_ok || accclr_ok
    || dist_ok || pause_ok || grp_ok || srd_ok || sclr_ok || prd_ok || pwr_ok
    || idis_ok || ien_ok;

  // ----------------------------------------------------------------
  // Parameter store and feedback total
  // ----------------------------------------------------------------
  logic [VAL_W-1:0] par_val_reg [PAR_N];
  logic [DP_W-1:0] par_dp_reg [PAR_N];
  logic [DATA_W-1:0] fb_cnt_reg;
  logic [DATA_W-1:0] fb_cnt_next;
  logic [7:0] last_item_reg;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < PAR_N; i++) begin
        par_val_reg[i] <= '0;
        par_dp_reg[i] <= DP_NONE;
      end
    end else if (req && pwr_ok) begin
      par_val_reg[pidx] <= wr_val;
      // Hex parameters keep no point position whatever was sent.
      par_dp_reg[pidx] <= par_dec ? wr_dp : DP_NONE;
    end
  end

  // Clearing is applied before the new pulse so a pulse in the clear cycle is kept.
  wire logic fb_clear = req && sclr_ok && (last_item_reg == DNO_STAT_FB);
  wire logic [DATA_W-1:0] fb_base = fb_clear ? '0 : fb_cnt_reg;
  wire logic [DATA_W-1:0] fb_step = fb_dir_i ? '1 : {{(DATA_W-1){1'b0}}, 1'b1};
  assign fb_cnt_next = fb_pulse_i ? (fb_base + fb_step) : fb_base;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fb_cnt_reg <= '0;
      last_item_reg <= DNO_00;
    end else begin
      fb_cnt_reg <= fb_cnt_next;
      if (req && srd_ok) begin
        last_item_reg <= dno;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply
  // ----------------------------------------------------------------
  wire logic rd_inhibit = (par_val_reg[PAR_INH_IDX] == PAR_INH_RD_OFF);
  wire logic prd_en = !(rd_inhibit && (pidx != PAR_INH_IDX));
  wire logic [DATA_W-1:0] rep_data = srd_ok ? fb_cnt_reg
    : (prd_ok ? {{(DATA_W-VAL_W){1'b0}}, par_val_reg[pidx]} : '0);
  wire logic [DP_W-1:0] rep_dp = prd_ok ? par_dp_reg[pidx] : DP_NONE;
  wire logic rep_disp = (prd_ok && !par_dec) ? DISP_RAW : DISP_CONV;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.resp_valid <= 1'b0;
      link.resp_ok <= 1'b0;
      link.resp_data <= '0;
      link.resp_dp <= DP_NONE;
      link.resp_disp <= DISP_CONV;
      link.resp_rden <= 1'b0;
    end else begin
      link.resp_valid <= req;
      if (req) begin
        link.resp_ok <= any_ok;
        link.resp_data <= rep_data;
        link.resp_dp <= rep_dp;
        link.resp_disp <= rep_disp;
        link.resp_rden <= prd_ok ? prd_en : 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Test operation settings
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_o <= MODE_EXIT;
      test_inputs_o <= '0;
      forced_outputs_o <= '0;
      test_speed_o <= '0;
      test_dist_o <= '0;
      group_o <= GRP_NONE;
    end else if (req) begin
      if (mode_ok) mode_o <= dat[2:0];
      if (tin_ok) test_inputs_o <= dat;
      if (fout_ok) forced_outputs_o <= dat;
      if (spd_ok) test_speed_o <= dat[15:0];
      if (dist_ok) test_dist_o <= dat;
      if (grp_ok) group_o <= dat[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      test_accel_o <= '0;
      test_pause_o <= 1'b0;
    end else begin
      test_pause_o <= req && pause_ok;
      if (req && accclr_ok) begin
        test_accel_o <= '0;
      end else if (req && acc_ok) begin
        test_accel_o <= dat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input disable
  // ----------------------------------------------------------------
  wire logic [DATA_W-1:0] raw_inputs = (other_inputs_i & ~KEEP_MASK)
    | (DATA_W'(forced_stop_input_i) << EMG_BIT)
    | (DATA_W'(forward_stroke_limit_i) << LSP_BIT)
    | (DATA_W'(reverse_stroke_limit_i) << LSN_BIT);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inputs_disabled_o <= 1'b0;
      dev_inputs_o <= '0;
    end else begin
      if (req && idis_ok) inputs_disabled_o <= 1'b1;
      else if (req && ien_ok) inputs_disabled_o <= 1'b0;
      dev_inputs_o <= inputs_disabled_o ? (raw_inputs & KEEP_MASK) : raw_inputs;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ssc_master.sv
// Purpose: Master station end: sends one request, collects and converts the reply.
// Assumes: The user waits for done before issuing the next request.
// Notes: Decimal conversion takes one cycle per binary bit.
`timescale 1ns/1ps
`default_nettype none
module ssc_master (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Link to slave
  ssc_link_if.host link,
  // Request from user
  input wire logic cmd_valid_i,
  input wire logic [ssc_pkg::CMD_W-1:0] cmd_i,
  input wire logic [ssc_pkg::CMD_W-1:0] dno_i,
  input wire logic [ssc_pkg::LEN_W-1:0] len_i,
  input wire logic [ssc_pkg::DATA_W-1:0] data_i,
  input wire logic wr_dec_i,
  input wire logic [ssc_pkg::DP_W-1:0] wr_dp_i,
  // Result to user
  output logic busy_o,
  output logic done_o,
  output logic ok_o,
  output logic unreadable_o,
  output logic disp_o,
  output logic [ssc_pkg::DP_W-1:0] dp_o,
  output logic [ssc_pkg::DATA_W-1:0] value_o,
  output logic [ssc_pkg::BCD_W-1:0] dec_digits_o
);
  import ssc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} ssc_state_e;
  ssc_state_e state_reg;
  logic [5:0] step_reg;
  logic [DATA_W-1:0] bin_reg;

  // ----------------------------------------------------------------
  // Write packing
  // ----------------------------------------------------------------
  wire logic par_wr = (cmd_i == CMD_PAR_WR) && (len_i == LEN8);
  wire logic [DP_W-1:0] pack_dp = wr_dec_i ? wr_dp_i : DP_NONE;
  wire logic [DATA_W-1:0] pack_data = par_wr ? {pack_dp, data_i[VAL_W-1:0]}
    : data_i;
  wire logic start = (state_reg == ST_IDLE) && cmd_valid_i;

  // ----------------------------------------------------------------
  // Decimal conversion by shift and add-three
  // ----------------------------------------------------------------
  logic [BCD_W-1:0] bcd_adj;
  genvar g;
  generate
    for (g = 0; g < BCD_W / 4; g++) begin : g_digit
      wire logic [3:0] dig = dec_digits_o[4*g +: 4];
      assign bcd_adj[4*g +: 4] = (dig >= BCD_ADJ_MIN) ? (dig + BCD_ADJ) : dig;
    end
  endgenerate

  wire logic conv_last = (step_reg == 6'(CONV_STEPS - 1));
  wire logic need_conv = link.resp_ok && link.resp_rden && (link.resp_disp == DISP_CONV);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      step_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: if (start) state_reg <= ST_WAIT;
        ST_WAIT: if (link.resp_valid) begin
          state_reg <= need_conv ? ST_CONV : ST_IDLE;
          step_reg <= '0;
        end
        ST_CONV: begin
          step_reg <= step_reg + 6'h01;
          if (conv_last) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link.req_valid <= 1'b0;
      link.req_cmd <= '0;
      link.req_dno <= '0;
      link.req_len <= '0;
      link.req_data <= '0;
    end else begin
      link.req_valid <= start;
      if (start) begin
        link.req_cmd <= cmd_i;
        link.req_dno <= dno_i;
        link.req_len <= len_i;
        link.req_data <= pack_data;
      end
    end
  end

  wire logic resp_in = (state_reg == ST_WAIT) && link.resp_valid;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      ok_o <= 1'b0;
      unreadable_o <= 1'b0;
      disp_o <= DISP_CONV;
      dp_o <= DP_NONE;
      value_o <= '0;
    end else begin
      busy_o <= (state_reg == ST_IDLE) ? start : !((state_reg == ST_CONV) && conv_last)
        && !(resp_in && !need_conv);
      done_o <= (resp_in && !need_conv) || ((state_reg == ST_CONV) && conv_last);
      if (resp_in) begin
        ok_o <= link.resp_ok;
        // A read-disabled reply has its data part thrown away.
        unreadable_o <= !link.resp_rden;
        value_o <= link.resp_rden ? link.resp_data : '0;
        disp_o <= link.resp_disp;
        dp_o <= link.resp_dp;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bin_reg <= '0;
      dec_digits_o <= '0;
    end else if (resp_in) begin
      bin_reg <= link.resp_data;
      dec_digits_o <= '0;
    end else if (state_reg == ST_CONV) begin
      {dec_digits_o, bin_reg} <= {bcd_adj[BCD_W-2:0], bin_reg, 1'b0};
    end
  end
endmodule
`default_nettype wire

// >>> tb/ssc_link_monitor.sv
// Purpose: Checker on the shared link between master and slave ends.
// Assumes: The master keeps request fields unchanged until its next request.
// Notes: Refusals are judged from the request fields still held at reply time.
`timescale 1ns/1ps
`default_nettype none
module ssc_link_monitor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Request side
  input wire logic req_valid,
  input wire logic [ssc_pkg::CMD_W-1:0] req_cmd,
  input wire logic [ssc_pkg::CMD_W-1:0] req_dno,
  input wire logic [ssc_pkg::LEN_W-1:0] req_len,
  input wire logic [ssc_pkg::DATA_W-1:0] req_data,
  // Reply side
  input wire logic resp_valid,
  input wire logic resp_ok,
  input wire logic resp_disp,
  input wire logic [ssc_pkg::DP_W-1:0] resp_dp,
  input wire logic resp_rden,
  input wire logic [ssc_pkg::DATA_W-1:0] resp_data
);
  import ssc_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  property p_answer;
    req_valid |=> resp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("reply missing");
  property p_pulse;
    resp_valid |-> $past(req_valid) && !$past(resp_valid);
  endproperty
  a_pulse: assert property (p_pulse) else $error("reply without request");
  property p_mode;
    resp_valid && req_cmd == CMD_MODE && (req_len != LEN4 || req_data[15:0] > MODE_MAX)
      |-> !resp_ok;
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode accepted");
  property p_speed;
    resp_valid && req_cmd == CMD_TEST && req_dno == DNO_SPEED && req_data[15:0] > SPEED_MAX
      |-> !resp_ok;
  endproperty
  a_speed: assert property (p_speed) else $error("bad speed accepted");
  property p_accel;
    resp_valid && req_cmd == CMD_TEST && req_dno == DNO_ACC && req_data[31] |-> !resp_ok;
  endproperty
  a_accel: assert property (p_accel) else $error("bad accel accepted");
  property p_pause;
    resp_valid && req_cmd == CMD_TEST && req_dno == DNO_PAUSE && req_data[15:0] != KEY
      |-> !resp_ok;
  endproperty
  a_pause: assert property (p_pause) else $error("bad pause key accepted");
  property p_group;
    resp_valid && req_cmd == CMD_GROUP && (req_data[7:0] < GRP_LO || req_data[7:0] > GRP_HI)
      |-> !resp_ok;
  endproperty
  a_group: assert property (p_group) else $error("bad group accepted");
  property p_par;
    resp_valid && req_cmd == CMD_PAR_RD && req_dno > DNO_PAR_MAX |-> !resp_ok;
  endproperty
  a_par: assert property (p_par) else $error("bad parameter number accepted");
  property p_stat;
    resp_valid && req_cmd == CMD_STAT_RD |-> resp_disp == DISP_CONV && resp_dp == DP_NONE;
  endproperty
  a_stat: assert property (p_stat) else $error("status info wrong");
  property p_clear;
    resp_valid && req_cmd == CMD_STAT_CLR && req_data[15:0] != KEY |-> !resp_ok;
  endproperty
  a_clear: assert property (p_clear) else $error("bad clear key accepted");
endmodule
`default_nettype wire

// >>> tb/servo_serial_command_handler_bench.sv
// Purpose: Self-checking bench joining master and slave ends.
// Assumes: One command in flight; inputs change 2 ns after the rising edge.
// Notes: Parameter 05 is made decimal so both write paths are reached.
`timescale 1ns/1ps
`default_nettype none
module servo_serial_command_handler_bench;
  import ssc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_i = '0;
  logic [7:0] dno_i = '0;
  logic [3:0] len_i = '0;
  logic [31:0] data_i = '0;
  logic wr_dec_i = 1'b0;
  logic [7:0] wr_dp_i = '0;
  logic fb_pulse_i = 1'b0;
  logic fb_dir_i = 1'b0;
  logic [2:0] lim = '0;
  logic [31:0] oth = '0;
  logic busy_o, done_o, ok_o, unreadable_o, disp_o, test_pause_o, inputs_disabled_o;
  logic [2:0] mode_o;
  logic [7:0] dp_o, group_o;
  logic [15:0] test_speed_o;
  logic [31:0] value_o, test_inputs_o, forced_outputs_o, test_accel_o, test_dist_o;
  logic [31:0] dev_inputs_o;
  logic [39:0] dec_digits_o;
  logic [31:0] seed = 32'h23140E63;
  int num_errors = 0;
  int total_checks = 0;
  int pauses = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (test_pause_o === 1'b1) pauses++;
  // ----------------------------------------------------------------
  // Ends and checker
  // ----------------------------------------------------------------
  ssc_link_if ssc_link_if_inst ();
  ssc_slave #(.DEC_MASK(91'h20)) ssc_slave_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .link(ssc_link_if_inst.dev), .fb_pulse_i(fb_pulse_i), .fb_dir_i(fb_dir_i),
    .forced_stop_input_i(lim[0]), .forward_stroke_limit_i(lim[1]),
    .reverse_stroke_limit_i(lim[2]), .other_inputs_i(oth), .mode_o(mode_o),
    .test_inputs_o(test_inputs_o), .forced_outputs_o(forced_outputs_o),
    .test_speed_o(test_speed_o), .test_accel_o(test_accel_o), .test_dist_o(test_dist_o),
    .test_pause_o(test_pause_o), .group_o(group_o), .inputs_disabled_o(inputs_disabled_o),
    .dev_inputs_o(dev_inputs_o));
  ssc_master ssc_master_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .link(ssc_link_if_inst.host), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .dno_i(dno_i),
    .len_i(len_i), .data_i(data_i), .wr_dec_i(wr_dec_i), .wr_dp_i(wr_dp_i), .busy_o(busy_o),
    .done_o(done_o), .ok_o(ok_o), .unreadable_o(unreadable_o), .disp_o(disp_o), .dp_o(dp_o),
    .value_o(value_o), .dec_digits_o(dec_digits_o));
  ssc_link_monitor ssc_link_monitor_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .req_valid(ssc_link_if_inst.req_valid), .req_cmd(ssc_link_if_inst.req_cmd),
    .req_dno(ssc_link_if_inst.req_dno), .req_len(ssc_link_if_inst.req_len),
    .req_data(ssc_link_if_inst.req_data), .resp_valid(ssc_link_if_inst.resp_valid),
    .resp_ok(ssc_link_if_inst.resp_ok), .resp_disp(ssc_link_if_inst.resp_disp),
    .resp_dp(ssc_link_if_inst.resp_dp), .resp_rden(ssc_link_if_inst.resp_rden),
    .resp_data(ssc_link_if_inst.resp_data));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [39:0] bcd(input logic [31:0] v);
    logic [39:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) begin
      r[i*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits for done under a bound, then checks the accept flag of the reply.
  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic [3:0] l,
      input logic [31:0] v, input logic eok, input logic dec = 1'b0, input logic [7:0] dp = '0);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    #2;
    {cmd_i, dno_i, len_i, data_i, wr_dec_i, wr_dp_i} = {c, d, l, v, dec, dp};
    cmd_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #2;
    cmd_valid_i = 1'b0;
    check("busy", busy_o, 1'b1);
    while (done_o !== 1'b1 && n < 60) begin
      @(posedge sys_clk_i);
      #2;
      n++;
    end
    // A reply that never comes runs the bound out and is counted here.
    check("done", {done_o, busy_o}, 2'b10);
    check("ok", ok_o, eok);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge sys_clk_i);
    num_errors++;
    results();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0] g;
    logic [7:0] d;
    repeat (2) @(posedge sys_clk_i);
    #2;
    nrst_i = 1'b1;
    for (int m = 0; m < 6; m++) begin
      send(CMD_MODE, DNO_00, LEN4, 32'(m), m < 5);
      check("mode", mode_o, (m < 5) ? m : 4);
    end
    send(CMD_MODE, DNO_00, LEN8, 32'h1, 1'b0);
    r = xs();
    send(CMD_TEST_IO, DNO_00, LEN8, r, 1'b1);
    check("inputs", test_inputs_o, r);
    r = xs();
    send(CMD_TEST_IO, DNO_FORCE_OUT, LEN8, r, 1'b1);
    check("outputs", forced_outputs_o, r);
    r = xs() & 32'h7FFF;
    send(CMD_TEST, DNO_SPEED, LEN4, r, 1'b1);
    check("speed", test_speed_o, r);
    send(CMD_TEST, DNO_SPEED, LEN4, 32'h7FFF, 1'b1);
    send(CMD_TEST, DNO_SPEED, LEN4, 32'h8000, 1'b0);
    check("speed", test_speed_o, 16'h7FFF);
    send(CMD_TEST, DNO_ACC, LEN8, 32'h7FFFFFFF, 1'b1);
    send(CMD_TEST, DNO_ACC, LEN8, 32'h80000000, 1'b0);
    check("accel", test_accel_o, 32'h7FFFFFFF);
    send(CMD_TEST, DNO_ACC_CLR, LEN4, 32'h1EA4, 1'b0);
    check("accel", test_accel_o, 32'h7FFFFFFF);
    send(CMD_TEST, DNO_ACC_CLR, LEN4, KEY, 1'b1);
    check("accel", test_accel_o, 32'h0);
    send(CMD_TEST, DNO_DIST, LEN8, 32'h80000000, 1'b1);
    check("dist", test_dist_o, 32'h80000000);
    r = 32'(pauses);
    send(CMD_TEST, DNO_PAUSE, LEN4, KEY, 1'b1);
    send(CMD_TEST, DNO_PAUSE, LEN4, 32'h1EA4, 1'b0);
    check("pauses", 32'(pauses), r + 1);
    d = GRP_NONE;
    for (g = 8'h60; g < 8'h68; g++) begin
      send(CMD_GROUP, DNO_00, LEN4, {24'h0, g}, g >= GRP_LO && g <= GRP_HI);
      if (g >= GRP_LO && g <= GRP_HI) d = g;
      check("group", group_o, d);
    end
    r = (xs() % 32'd63) + 32'd1;
    @(posedge sys_clk_i);
    #2;
    fb_pulse_i = 1'b1;
    repeat (r) @(posedge sys_clk_i);
    #2;
    fb_pulse_i = 1'b0;
    send(CMD_STAT_RD, DNO_STAT_FB, 4'h0, 32'h0, 1'b1);
    check("fb", value_o, r);
    check("digits", dec_digits_o, bcd(r));
    send(CMD_STAT_CLR, DNO_00, LEN4, 32'h1EA4, 1'b0);
    send(CMD_STAT_CLR, DNO_00, LEN4, KEY, 1'b1);
    send(CMD_STAT_RD, DNO_STAT_FB, 4'h0, 32'h0, 1'b1);
    check("fb", value_o, 32'h0);
    // One downward count from zero wraps to the widest value the converter must handle.
    fb_dir_i = 1'b1;
    fb_pulse_i = 1'b1;
    @(posedge sys_clk_i);
    #2;
    fb_pulse_i = 1'b0;
    fb_dir_i = 1'b0;
    send(CMD_STAT_RD, DNO_STAT_FB, 4'h0, 32'h0, 1'b1);
    check("fbdown", value_o, 32'hFFFFFFFF);
    check("digits", dec_digits_o, bcd(32'hFFFFFFFF));
    d = 8'(xs() % 91);
    if (d == 8'h05 || d == 8'h13) d = 8'h07;
    r = xs() & 32'hFFFFFF;
    send(CMD_PAR_WR, d, LEN8, r, 1'b1);
    send(CMD_PAR_RD, d, 4'h0, 32'h0, 1'b1);
    check("par", {value_o[23:0], disp_o, dp_o}, {r[23:0], DISP_RAW, DP_NONE});
    send(CMD_PAR_WR, 8'h05, LEN8, 32'h9B, 1'b0, 1'b1, 8'h00);
    send(CMD_PAR_WR, 8'h05, LEN8, 32'h9B, 1'b1, 1'b1, 8'h02);
    send(CMD_PAR_RD, 8'h05, 4'h0, 32'h0, 1'b1);
    check("pdec", {disp_o, dp_o}, {DISP_CONV, 8'h02});
    check("pdig", dec_digits_o, bcd(32'd155));
    send(CMD_PAR_RD, DNO_PAR_MAX, 4'h0, 32'h0, 1'b1);
    send(CMD_PAR_RD, 8'h5B, 4'h0, 32'h0, 1'b0);
    send(CMD_PAR_WR, 8'h13, LEN8, 32'h0E, 1'b1);
    send(CMD_PAR_RD, 8'h05, 4'h0, 32'h0, 1'b1);
    check("unread", unreadable_o, 1'b1);
    send(CMD_PAR_RD, 8'h13, 4'h0, 32'h0, 1'b1);
    check("unread", unreadable_o, 1'b0);
    lim = 3'(xs());
    oth = xs();
    r = {15'h0, lim[0], 13'h0, lim[2], lim[1], 1'b0};
    send(CMD_IN_DIS, DNO_00, LEN4, KEY, 1'b1);
    check("dis", {inputs_disabled_o, dev_inputs_o}, {1'b1, r});
    send(CMD_IN_DIS, DNO_IN_EN, LEN4, KEY, 1'b1);
    check("en", {inputs_disabled_o, dev_inputs_o}, {1'b0, r | (oth & ~KEEP_MASK)});
    results();
  end
endmodule
`default_nettype wire
